// *** ecc_sign_pkg.sv ***
package ecc_sign_pkg;
  // Request opcodes
  localparam logic [7:0] OP_INIT = 8'h01;
  localparam logic [7:0] OP_UPDATE = 8'h02;
  localparam logic [7:0] OP_FINALIZE = 8'h03;
  localparam logic [7:0] OP_ONESHOT = 8'h04;
  localparam logic [7:0] OP_PREHASH = 8'h05;
  localparam logic [7:0] ALG_ECDSA_SHA256 = 8'h00;
  localparam logic [7:0] KEY_INDEX_MAX = 8'h04;
  localparam int KEY_COUNT = 5;
  // Source selector value that means inline data in the command buffer
  localparam logic [7:0] SRC_COMMAND_BUFFER = 8'h00;
  localparam logic [7:0] PREHASH_LEN = 8'h20;
  localparam int SIG_BYTES = 64;
  // Status word bytes
  localparam logic [7:0] SW1_BYTE = 8'h91;
  localparam logic [7:0] SW2_OK = 8'h00;
  localparam logic [7:0] ERR_ACCESS_REFUSED = 8'h9d;
  localparam logic [7:0] ERR_LENGTH = 8'h7e;
  localparam logic [7:0] ERR_BAD_OPCODE = 8'h6e;
  localparam logic [7:0] ERR_BAD_ALG = 8'h6c;
  localparam logic [7:0] ERR_BAD_KEY = 8'h6a;
  localparam logic [7:0] ERR_NO_SESSION = 8'h69;
  // Register byte offsets
  localparam logic [7:0] REG_SIGN_ATTR = 8'h00;
  localparam logic [7:0] REG_LIMIT_EN = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;
  // Interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  // Reset values
  localparam logic [4:0] SIGN_ATTR_RESET = 5'h00;
  localparam logic [4:0] LIMIT_EN_RESET = 5'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
endpackage

// *** sig_buffer.sv ***
`timescale 1ns/1ps
module sig_buffer #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic core_clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge core_clk_in)
  begin
    if (wr_en_in)
    begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule // sig_buffer

// *** sign_apb_regs.sv ***
`timescale 1ns/1ps
module sign_apb_regs (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic done_evt_in,
  input wire logic err_evt_in,
  input wire logic session_in,
  input wire logic busy_in,
  input wire logic [7:0] last_sw2_in,
  output logic [4:0] sign_attr_out,
  output logic [4:0] limit_en_out,
  output logic irq_out
);
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [1:0] status_nxt;
  logic access;
  logic mapped;
  logic [31:0] rd_value;

  assign access = psel && penable && pready;
  assign mapped = paddr == ecc_sign_pkg::REG_SIGN_ATTR || paddr == ecc_sign_pkg::REG_LIMIT_EN
    || paddr == ecc_sign_pkg::REG_IRQ_STATUS || paddr == ecc_sign_pkg::REG_IRQ_MASK
    || paddr == ecc_sign_pkg::REG_STATE;

  always_comb
  begin
    rd_value = 32'h0;
    unique case (paddr)
      ecc_sign_pkg::REG_SIGN_ATTR: rd_value = {27'h0, sign_attr_out};
      ecc_sign_pkg::REG_LIMIT_EN: rd_value = {27'h0, limit_en_out};
      ecc_sign_pkg::REG_IRQ_STATUS: rd_value = {30'h0, status_r};
      ecc_sign_pkg::REG_IRQ_MASK: rd_value = {30'h0, mask_r};
      ecc_sign_pkg::REG_STATE: rd_value = {22'h0, busy_in, session_in, last_sw2_in};
      default: rd_value = 32'h0;
    endcase
  end

  // One wait state, then answer
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_value : 32'h0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sign_attr_out <= ecc_sign_pkg::SIGN_ATTR_RESET;
      limit_en_out <= ecc_sign_pkg::LIMIT_EN_RESET;
      mask_r <= ecc_sign_pkg::IRQ_MASK_RESET;
    end
    else if (access && pwrite)
    begin
      if (paddr == ecc_sign_pkg::REG_SIGN_ATTR)
      begin
        sign_attr_out <= pwdata[4:0];
      end
      if (paddr == ecc_sign_pkg::REG_LIMIT_EN)
      begin
        limit_en_out <= pwdata[4:0];
      end
      if (paddr == ecc_sign_pkg::REG_IRQ_MASK)
      begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_comb
  begin
    status_nxt = status_r;
    if (access && pwrite && paddr == ecc_sign_pkg::REG_IRQ_STATUS)
    begin
      status_nxt = status_r & ~pwdata[1:0];
    end
    status_nxt[ecc_sign_pkg::IRQ_DONE_BIT] = status_nxt[ecc_sign_pkg::IRQ_DONE_BIT] | done_evt_in;
    status_nxt[ecc_sign_pkg::IRQ_ERR_BIT] = status_nxt[ecc_sign_pkg::IRQ_ERR_BIT] | err_evt_in;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status_r <= 2'h0;
      irq_out <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq_out <= |(status_nxt & mask_r);
    end
  end
endmodule // sign_apb_regs

// *** ecc_sign_command_parser.sv ***
`timescale 1ns/1ps
module ecc_sign_command_parser (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_out,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_last_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic rsp_last_out,
  input wire logic rsp_ready_in,
  input wire logic [4:0] key_limit_reached_in,
  output logic core_begin_out,
  output logic [2:0] core_key_out,
  output logic core_prehash_out,
  output logic core_absorb_out,
  output logic [7:0] core_byte_out,
  output logic core_fetch_out,
  output logic [7:0] core_fetch_len_out,
  output logic core_finish_out,
  output logic core_abort_out,
  input wire logic core_sig_valid_in,
  input wire logic [7:0] core_sig_byte_in
);
  typedef enum logic [3:0] {
    ST_OP, ST_ALG, ST_KEY, ST_SRC, ST_LEN, ST_DATA, ST_DRAIN, ST_EXEC,
    ST_WAIT_SIG, ST_SIG_RD, ST_SIG_LD, ST_SW1, ST_SW2, ST_FLUSH
  } state_type;

  state_type state_r, state_nxt;
  logic [7:0] op_r;
  logic [7:0] len_r;
  logic [7:0] err_r;
  logic [7:0] fail_code;
  logic [5:0] sig_idx_r;
  logic session_r;
  logic take;
  logic fail;
  logic rsp_free;
  logic [4:0] sign_attr;
  logic [4:0] limit_en;
  logic [7:0] sig_rd_data;
  logic done_evt_r;
  logic err_evt_r;

  assign take = cmd_valid_in && cmd_ready_out;
  assign rsp_free = !rsp_valid_out || rsp_ready_in;

  sign_apb_regs u_regs (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .done_evt_in(done_evt_r),
    .err_evt_in(err_evt_r),
    .session_in(session_r),
    .busy_in(state_r != ST_OP),
    .last_sw2_in(err_r),
    .sign_attr_out(sign_attr),
    .limit_en_out(limit_en),
    .irq_out(irq_out)
  );

  sig_buffer #(.DEPTH(ecc_sign_pkg::SIG_BYTES), .WIDTH(8)) u_sig (
    .core_clk_in(core_clk_in),
    .wr_en_in(state_r == ST_WAIT_SIG && core_sig_valid_in),
    .wr_addr_in(sig_idx_r),
    .wr_data_in(core_sig_byte_in),
    .rd_addr_in(sig_idx_r),
    .rd_data_out(sig_rd_data)
  );

  // Request decode and checks
  always_comb
  begin
    state_nxt = state_r;
    fail = 1'b0;
    fail_code = ecc_sign_pkg::SW2_OK;
    unique case (state_r)
      ST_OP:
        if (take)
        begin
          if (cmd_byte_in == ecc_sign_pkg::OP_INIT || cmd_byte_in == ecc_sign_pkg::OP_ONESHOT
              || cmd_byte_in == ecc_sign_pkg::OP_PREHASH)
            state_nxt = ST_ALG;
          else if (cmd_byte_in == ecc_sign_pkg::OP_UPDATE || cmd_byte_in == ecc_sign_pkg::OP_FINALIZE)
          begin
            if (!session_r)
            begin
              fail = 1'b1;
              fail_code = ecc_sign_pkg::ERR_NO_SESSION;
            end
            else
              state_nxt = ST_SRC;
          end
          else
          begin
            fail = 1'b1;
            fail_code = ecc_sign_pkg::ERR_BAD_OPCODE;
          end
        end
      ST_ALG:
        if (take)
        begin
          if (cmd_byte_in != ecc_sign_pkg::ALG_ECDSA_SHA256)
          begin
            fail = 1'b1;
            fail_code = ecc_sign_pkg::ERR_BAD_ALG;
          end
          else
            state_nxt = ST_KEY;
        end
      ST_KEY:
        if (take)
        begin
          fail = 1'b1;
          if (cmd_byte_in > ecc_sign_pkg::KEY_INDEX_MAX)
            fail_code = ecc_sign_pkg::ERR_BAD_KEY;
          else if (!sign_attr[cmd_byte_in[2:0]])
            fail_code = ecc_sign_pkg::ERR_ACCESS_REFUSED;
          else if (limit_en[cmd_byte_in[2:0]] && key_limit_reached_in[cmd_byte_in[2:0]])
            fail_code = ecc_sign_pkg::ERR_ACCESS_REFUSED;
          else
          begin
            fail = 1'b0;
            state_nxt = ST_SRC;
          end
        end
      ST_SRC:
        if (take)
        begin
          if (cmd_byte_in == ecc_sign_pkg::SRC_COMMAND_BUFFER)
            state_nxt = cmd_last_in ? ST_EXEC : ST_DATA;
          else
            state_nxt = ST_LEN;
        end
      ST_LEN:
        if (take)
        begin
          if (!cmd_last_in)
          begin
            fail = 1'b1;
            fail_code = ecc_sign_pkg::ERR_LENGTH;
          end
          else
            state_nxt = ST_EXEC;
        end
      ST_DATA:
        if (take && cmd_last_in)
          state_nxt = ST_EXEC;
      ST_DRAIN:
        if (take && cmd_last_in)
          state_nxt = ST_SW1;
      ST_EXEC:
        if (op_r == ecc_sign_pkg::OP_PREHASH && len_r != ecc_sign_pkg::PREHASH_LEN)
        begin
          fail = 1'b1;
          fail_code = ecc_sign_pkg::ERR_LENGTH;
        end
        else if (op_r == ecc_sign_pkg::OP_INIT || op_r == ecc_sign_pkg::OP_UPDATE)
          state_nxt = ST_SW1;
        else
          state_nxt = ST_WAIT_SIG;
      ST_WAIT_SIG:
        if (core_sig_valid_in && sig_idx_r == 6'(ecc_sign_pkg::SIG_BYTES - 1))
          state_nxt = ST_SIG_RD;
      ST_SIG_RD:
        state_nxt = ST_SIG_LD;
      ST_SIG_LD:
        if (rsp_free)
          state_nxt = (sig_idx_r == 6'(ecc_sign_pkg::SIG_BYTES - 1)) ? ST_SW1 : ST_SIG_RD;
      ST_SW1:
        if (rsp_free)
          state_nxt = ST_SW2;
      ST_SW2:
        if (rsp_free)
          state_nxt = ST_FLUSH;
      ST_FLUSH:
        if (rsp_free)
          state_nxt = ST_OP;
    endcase
    // A request that ends before its fields are complete is malformed
    if (!fail && take && cmd_last_in && (state_r == ST_OP || state_r == ST_ALG || state_r == ST_KEY
        || (state_r == ST_SRC && cmd_byte_in != ecc_sign_pkg::SRC_COMMAND_BUFFER)))
    begin
      fail = 1'b1;
      fail_code = ecc_sign_pkg::ERR_LENGTH;
    end
    if (fail)
      state_nxt = (state_r == ST_EXEC || cmd_last_in) ? ST_SW1 : ST_DRAIN;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_OP;
      cmd_ready_out <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cmd_ready_out <= state_nxt inside {ST_OP, ST_ALG, ST_KEY, ST_SRC, ST_LEN, ST_DATA, ST_DRAIN};
    end
  end

  // Request fields and answer code
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      op_r <= 8'h00;
      len_r <= 8'h00;
      err_r <= ecc_sign_pkg::SW2_OK;
    end
    else
    begin
      if (take && state_r == ST_OP)
      begin
        op_r <= cmd_byte_in;
        len_r <= 8'h00;
        err_r <= ecc_sign_pkg::SW2_OK;
      end
      if (take && state_r == ST_LEN)
        len_r <= cmd_byte_in;
      else if (take && state_r == ST_DATA && len_r != 8'hff)
        len_r <= len_r + 8'h01;
      if (fail)
        err_r <= fail_code;
    end
  end

  // Session tracking
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      session_r <= 1'b0;
    else if (fail || (take && state_r == ST_KEY))
      session_r <= 1'b0;
    else if (state_r == ST_EXEC && op_r == ecc_sign_pkg::OP_INIT)
      session_r <= 1'b1;
    else if (state_r == ST_EXEC && op_r == ecc_sign_pkg::OP_FINALIZE)
      session_r <= 1'b0;
  end

  // Signing core strobes
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      core_begin_out <= 1'b0;
      core_key_out <= 3'h0;
      core_prehash_out <= 1'b0;
      core_absorb_out <= 1'b0;
      core_byte_out <= 8'h00;
      core_fetch_out <= 1'b0;
      core_fetch_len_out <= 8'h00;
      core_finish_out <= 1'b0;
      core_abort_out <= 1'b0;
    end
    else
    begin
      core_begin_out <= take && state_r == ST_KEY && !fail;
      if (take && state_r == ST_KEY && !fail)
      begin
        core_key_out <= cmd_byte_in[2:0];
        core_prehash_out <= op_r == ecc_sign_pkg::OP_PREHASH;
      end
      core_absorb_out <= take && state_r == ST_DATA;
      if (take && state_r == ST_DATA)
        core_byte_out <= cmd_byte_in;
      core_fetch_out <= take && state_r == ST_LEN && !fail;
      if (take && state_r == ST_LEN)
        core_fetch_len_out <= cmd_byte_in;
      core_finish_out <= state_r == ST_EXEC && !fail && state_nxt == ST_WAIT_SIG;
      core_abort_out <= fail;
    end
  end

  // Signature capture and answer stream
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sig_idx_r <= 6'h00;
      rsp_valid_out <= 1'b0;
      rsp_byte_out <= 8'h00;
      rsp_last_out <= 1'b0;
      done_evt_r <= 1'b0;
      err_evt_r <= 1'b0;
    end
    else
    begin
      done_evt_r <= 1'b0;
      err_evt_r <= 1'b0;
      if (state_r == ST_EXEC)
        sig_idx_r <= 6'h00;
      else if ((state_r == ST_WAIT_SIG && core_sig_valid_in) || (state_r == ST_SIG_LD && rsp_free))
        sig_idx_r <= sig_idx_r + 6'h01;
      if (rsp_free && (state_r == ST_SIG_LD || state_r == ST_SW1 || state_r == ST_SW2))
      begin
        rsp_valid_out <= 1'b1;
        rsp_last_out <= state_r == ST_SW2;
        unique case (state_r)
          ST_SIG_LD: rsp_byte_out <= sig_rd_data;
          ST_SW1: rsp_byte_out <= ecc_sign_pkg::SW1_BYTE;
          default: rsp_byte_out <= err_r;
        endcase
        done_evt_r <= state_r == ST_SW2;
        err_evt_r <= state_r == ST_SW2 && err_r != ecc_sign_pkg::SW2_OK;
      end
      else if (rsp_ready_in)
      begin
        rsp_valid_out <= 1'b0;
        rsp_last_out <= 1'b0;
      end
    end
  end

  a_bad_alg_err: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    take && state_r == ST_ALG && cmd_byte_in != 8'h00 |=> err_r == 8'h6c)
    else $error("bad algorithm not refused");
  a_key_range_err: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    take && state_r == ST_KEY && cmd_byte_in > 8'h04 |=> err_r == 8'h6a && !core_begin_out)
    else $error("key index out of range accepted");
  a_attr_refused: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    take && state_r == ST_KEY && cmd_byte_in <= 8'h04 && !sign_attr[cmd_byte_in[2:0]] |=> err_r == 8'h9d)
    else $error("key without signing attribute not refused");
  a_limit_refused: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    take && state_r == ST_KEY && cmd_byte_in <= 8'h04 && limit_en[cmd_byte_in[2:0]]
    && key_limit_reached_in[cmd_byte_in[2:0]] |=> err_r == 8'h9d)
    else $error("exhausted key not refused");
  a_prehash_len: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    state_r == ST_EXEC && op_r == 8'h05 && len_r != 8'h20 |=> err_r == 8'h7e && state_r == ST_SW1)
    else $error("prehash length error missing");
  a_session_gate: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    take && state_r == ST_OP && (cmd_byte_in == 8'h02 || cmd_byte_in == 8'h03) && !session_r
    |=> err_r == 8'h69 ##1 !session_r)
    else $error("update without session accepted");
  a_update_absorb: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    take && state_r == ST_DATA |=> core_absorb_out && core_byte_out == $past(cmd_byte_in))
    else $error("inline byte not passed to signer");
  a_sig_then_sw: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    state_r == ST_SIG_LD && rsp_free && sig_idx_r == 6'h3f |=> state_r == ST_SW1 ##[1:1000]
    (rsp_valid_out && rsp_byte_out == 8'h91))
    else $error("status word does not follow signature");
  a_status_tail: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    state_r == ST_SW2 && rsp_free |=> rsp_valid_out && rsp_last_out && rsp_byte_out == err_r)
    else $error("status tail byte wrong");
endmodule // ecc_sign_command_parser

// *** sign_core_model.sv ***
`timescale 1ns/1ps
module sign_core_model (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] core_key_in,
  input wire logic core_finish_in,
  input wire logic [3:0] delay_in,
  output logic sig_valid_out,
  output logic [7:0] sig_byte_out
);
  logic [7:0] cnt_r;
  logic [4:0] wait_r;
  logic [2:0] key_r;
  // Byte pattern depends on the key so a wrong key shows in the answer
  assign sig_byte_out = cnt_r ^ {key_r, 5'h00};
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 8'h00;
      wait_r <= 5'h00;
      key_r <= 3'h0;
      sig_valid_out <= 1'b0;
    end
    else if (core_finish_in)
    begin
      key_r <= core_key_in;
      wait_r <= {1'b0, delay_in} + 5'h01;
      cnt_r <= 8'h00;
      sig_valid_out <= 1'b0;
    end
    else if (wait_r != 5'h00)
    begin
      wait_r <= wait_r - 5'h01;
      sig_valid_out <= (wait_r == 5'h01);
    end
    else if (sig_valid_out)
    begin
      sig_valid_out <= (cnt_r != 8'h3f);
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // sign_core_model

// *** ecc_sign_command_parser_tb_top.sv ***
`timescale 1ns/1ps
module ecc_sign_command_parser_tb_top;
  logic core_clk_in = 0;
  logic rst_n_in = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq_out, err;
  logic cmd_valid_in = 0, cmd_last_in = 0, cmd_ready_out;
  logic [7:0] cmd_byte_in = 0, rsp_byte_out, core_byte_out, fetch_len, fetch_exp;
  logic rsp_valid_out, rsp_last_out, rsp_ready_in = 0;
  logic [4:0] key_limit_reached_in = 0;
  logic core_begin_out, core_prehash_out, core_absorb_out, core_fetch_out, core_finish_out, core_abort_out;
  logic [2:0] core_key_out;
  logic sig_valid;
  logic [7:0] sig_byte;
  logic [3:0] dly = 0;
  logic [8:0] exp_q[$];
  logic [7:0] abs_q[$];
  logic [7:0] code_exp = 0;
  logic [2:0] key_exp = 0;
  logic prehash_exp = 0;
  int fail_count = 0;
  int compares = 0;

  always #2 core_clk_in = ~core_clk_in;

  ecc_sign_command_parser dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_out(irq_out), .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in), .cmd_last_in(cmd_last_in),
    .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_byte_out(rsp_byte_out),
    .rsp_last_out(rsp_last_out), .rsp_ready_in(rsp_ready_in), .key_limit_reached_in(key_limit_reached_in),
    .core_begin_out(core_begin_out), .core_key_out(core_key_out), .core_prehash_out(core_prehash_out),
    .core_absorb_out(core_absorb_out), .core_byte_out(core_byte_out), .core_fetch_out(core_fetch_out),
    .core_fetch_len_out(fetch_len), .core_finish_out(core_finish_out), .core_abort_out(core_abort_out),
    .core_sig_valid_in(sig_valid), .core_sig_byte_in(sig_byte));

  sign_core_model core (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .core_key_in(core_key_out),
    .core_finish_in(core_finish_out), .delay_in(dly), .sig_valid_out(sig_valid), .sig_byte_out(sig_byte));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk_in);
  endtask

  task automatic send(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      cmd_valid_in <= 1;
      cmd_byte_in <= b[i];
      cmd_last_in <= (i == b.size() - 1);
      do @(posedge core_clk_in); while (cmd_ready_out !== 1'b1);
    end
    cmd_valid_in <= 0;
    cmd_last_in <= 0;
    for (int n = 0; n < 2000 && exp_q.size() != 0; n++)
      @(posedge core_clk_in);
    chk("answer_drained", exp_q.size(), 0);
    chk("absorb_drained", abs_q.size(), 0);
  endtask

  task automatic expect_rsp(input logic sig, input logic [2:0] key, input logic [7:0] code);
    code_exp = code;
    if (sig)
      for (int i = 0; i < ecc_sign_pkg::SIG_BYTES; i++)
        exp_q.push_back({1'b0, 8'(i) ^ {key, 5'h00}});
    exp_q.push_back({1'b0, ecc_sign_pkg::SW1_BYTE});
    exp_q.push_back({1'b1, code});
  endtask

  // Builds a request; a non-zero source sends a length byte instead of inline data
  task automatic req(input logic [7:0] op, input logic [7:0] alg, input logic [7:0] key, input logic [7:0] src,
    input logic [7:0] n);
    logic [7:0] b[$];
    logic [7:0] d;
    b.push_back(op);
    if (op == 8'h01 || op == 8'h04 || op == 8'h05)
    begin
      b.push_back(alg);
      b.push_back(key);
      key_exp = key[2:0];
      prehash_exp = (op == 8'h05);
    end
    b.push_back(src);
    fetch_exp = n;
    if (src != ecc_sign_pkg::SRC_COMMAND_BUFFER)
      b.push_back(n);
    else
      repeat (n)
      begin
        d = 8'($urandom);
        b.push_back(d);
        // Inline bytes reach the signer only once all header fields were accepted
        if (code_exp == 8'h00 || code_exp == ecc_sign_pkg::ERR_LENGTH)
          abs_q.push_back(d);
      end
    send(b);
  endtask

  always @(posedge core_clk_in)
    if (core_absorb_out === 1'b1)
      chk("absorb", core_byte_out, abs_q.size() != 0 ? abs_q.pop_front() : 8'hxx);

  always @(posedge core_clk_in)
    if (core_begin_out === 1'b1)
    begin
      chk("begin_key", core_key_out, key_exp);
      chk("begin_prehash", core_prehash_out, prehash_exp);
    end

  always @(posedge core_clk_in)
    if (core_abort_out === 1'b1)
      chk("abort", code_exp != 8'h00, 1);

  always @(posedge core_clk_in)
    if (rsp_valid_out === 1'b1 && rsp_ready_in === 1'b1)
      chk("rsp", {rsp_last_out, rsp_byte_out}, exp_q.size() != 0 ? exp_q.pop_front() : 9'hxxx);

  always @(posedge core_clk_in)
    if (core_fetch_out === 1'b1)
      chk("fetch_len", fetch_len, fetch_exp);

  always @(posedge core_clk_in)
  begin
    rsp_ready_in <= ($urandom % 4) != 0;
    dly <= 4'($urandom);
  end

  initial
  begin
    repeat (40000) @(posedge core_clk_in);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(73));
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1;
    apb(0, 8'h00, 0);
    chk("attr_reset", rd, 0);
    apb(0, 8'h04, 0);
    chk("limit_reset", rd, 0);
    apb(0, 8'h10, 0);
    chk("state_reset", rd, 0);
    apb(0, 8'h14, 0);
    chk("unmapped_err", err, 1);
    apb(1, 8'h00, 32'h1d);
    apb(1, 8'h0c, 32'h3);
    for (int k = 0; k < 5; k++)
    begin
      expect_rsp(k != 1, 3'(k), k == 1 ? 8'h9d : 8'h00);
      req(8'h04, 8'h00, 8'(k), 8'h00, 8'(1 + $urandom % 40));
    end
    chk("irq_set", irq_out, 1);
    apb(1, 8'h08, 32'h3);
    repeat (2) @(posedge core_clk_in);
    chk("irq_clear", irq_out, 0);
    apb(1, 8'h0c, 0);
    expect_rsp(0, 0, 8'h6c);
    req(8'h04, 8'h01, 8'h00, 8'h00, 8'h03);
    chk("irq_masked", irq_out, 0);
    apb(0, 8'h08, 0);
    chk("irq_status", rd, 32'h3);
    apb(1, 8'h08, 32'h3);
    expect_rsp(0, 0, 8'h6a);
    req(8'h04, 8'h00, 8'h05, 8'h00, 8'h02);
    expect_rsp(0, 0, 8'h6e);
    req(8'h07, 8'h00, 8'h00, 8'h00, 8'h01);
    expect_rsp(0, 0, 8'h69);
    req(8'h02, 8'h00, 8'h00, 8'h00, 8'h03);
    expect_rsp(0, 0, 8'h00);
    req(8'h01, 8'h00, 8'h03, 8'h00, 8'h05);
    apb(0, 8'h10, 0);
    chk("session_open", rd, 32'h100);
    expect_rsp(0, 0, 8'h00);
    req(8'h02, 8'h00, 8'h00, 8'h00, 8'h03);
    expect_rsp(0, 0, 8'h00);
    req(8'h02, 8'h00, 8'h00, 8'h01, 8'h10);
    expect_rsp(1, 3, 8'h00);
    req(8'h03, 8'h00, 8'h00, 8'h00, 8'h02);
    expect_rsp(0, 0, 8'h69);
    req(8'h03, 8'h00, 8'h00, 8'h00, 8'h02);
    expect_rsp(0, 0, 8'h00);
    req(8'h01, 8'h00, 8'h00, 8'h00, 8'h01);
    expect_rsp(0, 0, 8'h7e);
    send({8'h02, 8'h01, 8'h10, 8'h55});
    expect_rsp(0, 0, 8'h69);
    req(8'h03, 8'h00, 8'h00, 8'h00, 8'h01);
    expect_rsp(1, 4, 8'h00);
    req(8'h05, 8'h00, 8'h04, 8'h00, 8'h20);
    expect_rsp(0, 0, 8'h7e);
    req(8'h05, 8'h00, 8'h04, 8'h00, 8'h1f);
    expect_rsp(1, 0, 8'h00);
    req(8'h05, 8'h00, 8'h00, 8'h02, 8'h20);
    expect_rsp(0, 0, 8'h7e);
    req(8'h05, 8'h00, 8'h00, 8'h02, 8'h21);
    key_limit_reached_in <= 5'h04;
    expect_rsp(1, 2, 8'h00);
    req(8'h04, 8'h00, 8'h02, 8'h00, 8'h04);
    apb(1, 8'h04, 32'h4);
    expect_rsp(0, 0, 8'h9d);
    req(8'h04, 8'h00, 8'h02, 8'h00, 8'h04);
    tally_and_finish();
  end
endmodule // ecc_sign_command_parser_tb_top
